//--- fifo_cfg_and_irq_line1_map.v
// Purpose: second interrupt pin routing and sample queue configuration with its queue
// Assumes: byte register port on core_clk; status inputs are core_clk levels
// Notes:   frame sync is a pin and is synchronised before use
`timescale 1ns/100ps
`include "fifo_cfg_defs.vh"
module fifo_cfg_and_irq_line1_map (
  input wire core_clk,
  input wire rstn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire nvm_complete,
  input wire nvm_request,
  input wire undervolt_latched,
  input wire overrange_latched,
  input wire parity_fault,
  input wire tap3_event,
  input wire tap2_event,
  input wire tap1_event,
  input wire activity_event,
  input wire frame_sync_pin,
  input wire pdm_mode,
  input wire smp_valid,
  input wire [1:0] smp_chan,
  input wire [15:0] smp_data,
  output reg smp_ready,
  output reg irq_pin_b,
  output reg queue_triggered,
  output reg watermark_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] route_b;
  reg [7:0] qctrl;
  reg [7:0] wmark_lo;
  reg watermark_flag;
  wire queue_tag_enable;
  wire queue_trigger_source;
  wire ptr_clear;
  wire [1:0] qmode;
  wire [8:0] wmark;
  wire wr_route;
  wire wr_qctrl;
  wire wr_wmark;
  wire rd_stat;
  wire rd_data;

  assign queue_tag_enable = qctrl[`QCTRL_TAG_EN];
  assign queue_trigger_source = qctrl[`QCTRL_EXT_TRIG];
  assign ptr_clear = qctrl[`QCTRL_PTR_CLR];
  assign qmode = qctrl[`QCTRL_MODE_HI:`QCTRL_MODE_LO];
  assign wmark = {qctrl[`QCTRL_WM_MSB], wmark_lo};
  assign wr_route = reg_wr && (reg_addr == `ROUTE_B_ADDR);
  assign wr_qctrl = reg_wr && (reg_addr == `QCTRL_ADDR);
  assign wr_wmark = reg_wr && (reg_addr == `WMARK_LO_ADDR);
  assign rd_stat = reg_rd && (reg_addr == `QSTAT_ADDR);
  assign rd_data = reg_rd && (reg_addr == `QDATA_ADDR);

  always @(posedge core_clk) begin
    if (!rstn) begin
      route_b <= `ROUTE_B_RESET;
      qctrl <= `QCTRL_RESET;
      wmark_lo <= `WMARK_LO_RESET;
    end else begin
      if (wr_route) begin
        route_b <= reg_wdata;
      end
      if (wr_qctrl) begin
        // reserved bits 2:1 stay zero
        qctrl <= reg_wdata & `QCTRL_WR_MASK;
      end
      if (wr_wmark) begin
        wmark_lo <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin b
  wire [7:0] status_vec;
  wire [7:0] routed;
  assign status_vec[7] = nvm_complete;
  assign status_vec[6] = nvm_request;
  assign status_vec[5] = undervolt_latched;
  assign status_vec[4] = overrange_latched;
  assign status_vec[3] = parity_fault;
  assign status_vec[2] = tap3_event;
  assign status_vec[1] = tap2_event;
  assign status_vec[0] = tap1_event;

  // one gate per route bit, bit position matches the route register
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_route
      assign routed[g] = status_vec[g] & route_b[g];
    end
  endgenerate

  // registered so the pin never glitches on a route write
  always @(posedge core_clk) begin
    if (!rstn) begin
      irq_pin_b <= 1'b0;
    end else begin
      irq_pin_b <= |routed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger selection
  reg frame_sync_pin_meta;
  reg frame_sync_pin_sync;
  reg trig_src_d;
  wire trig_src;

  always @(posedge core_clk) begin
    if (!rstn) begin
      frame_sync_pin_meta <= 1'b0;
      frame_sync_pin_sync <= 1'b0;
      trig_src_d <= 1'b0;
    end else begin
      frame_sync_pin_meta <= frame_sync_pin;
      frame_sync_pin_sync <= frame_sync_pin_meta;
      trig_src_d <= trig_src;
    end
  end

  // source picked every cycle, only used while the mode field is 3
  assign trig_src = queue_trigger_source ? frame_sync_pin_sync : activity_event;

  ////////////////////////////////////////////////////////////////////////////
  // two-entry skid buffer on the sample input
  reg [17:0] skid_data [0:1];
  reg [1:0] skid_cnt;
  wire skid_valid;
  wire [17:0] in_word;
  wire skid_pop;
  wire skid_push;
  wire [17:0] head_word;

  // channel id always stored, so the tag can be switched on with words queued
  assign in_word = {smp_chan, smp_data};
  assign skid_push = smp_valid && smp_ready;
  assign skid_valid = (skid_cnt != 2'd0);
  assign head_word = skid_data[0];

  always @(posedge core_clk) begin
    if (!rstn || ptr_clear) begin
      skid_cnt <= 2'd0;
      skid_data[0] <= 18'h00000;
      skid_data[1] <= 18'h00000;
    end else begin
      case ({skid_push, skid_pop})
        2'b10: begin
          skid_data[skid_cnt[0]] <= in_word;
          skid_cnt <= skid_cnt + 2'd1;
        end
        2'b01: begin
          skid_data[0] <= skid_data[1];
          skid_cnt <= skid_cnt - 2'd1;
        end
        2'b11: begin
          if (skid_cnt == 2'd1) begin
            skid_data[0] <= in_word;
          end else begin
            skid_data[0] <= skid_data[1];
            skid_data[1] <= in_word;
          end
        end
        default: begin
          skid_cnt <= skid_cnt;
        end
      endcase
    end
  end

  // registered ready: free room counts the slot popped this cycle only if one slot is in use
  always @(posedge core_clk) begin
    if (!rstn) begin
      smp_ready <= 1'b0;
    end else begin
      smp_ready <= (skid_cnt == 2'd0) ||
                   ((skid_cnt == 2'd1) && !(skid_push && !skid_pop));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // queue pointers and fill level
  reg [8:0] wr_ptr;
  reg [8:0] rd_ptr;
  reg [8:0] level;
  reg [1:0] rd_state;
  reg [1:0] next_rd_state;
  wire q_full;
  wire q_empty;
  wire accept;
  wire drop_old;
  wire q_write;
  wire q_read;
  wire mode_ok;

  localparam RS_IDLE = 2'b00;
  localparam RS_FETCH = 2'b01;
  localparam RS_HOLD = 2'b10;

  assign mode_ok = (qmode != `MODE_OFF) && !pdm_mode;
  assign q_full = (level == `QDEPTH);
  assign q_empty = (level == 9'd0);
  // trigger mode only fills after the trigger; normal stops full; stream drops oldest
  assign accept = mode_ok && ((qmode != `MODE_TRIGGER) || queue_triggered);
  // a read in the same cycle frees a slot, so nothing is dropped then
  assign drop_old = q_full && ((qmode == `MODE_STREAM) || (qmode == `MODE_TRIGGER)) &&
                    !q_read;
  assign skid_pop = skid_valid && (!accept || !q_full || drop_old) && !ptr_clear;
  assign q_write = skid_pop && accept;
  assign q_read = (rd_state == RS_IDLE) && rd_data && !q_empty && !ptr_clear;

  function [8:0] ptr_inc;
    input [8:0] p;
    begin
      ptr_inc = (p == `QDEPTH - 1) ? 9'd0 : p + 9'd1;
    end
  endfunction

  always @(posedge core_clk) begin
    if (!rstn || ptr_clear) begin
      wr_ptr <= 9'd0;
      rd_ptr <= 9'd0;
      level <= 9'd0;
      queue_triggered <= 1'b0;
    end else begin
      if (qmode == `MODE_TRIGGER && trig_src && !trig_src_d) begin
        queue_triggered <= 1'b1;
      end else if (qmode != `MODE_TRIGGER) begin
        queue_triggered <= 1'b0;
      end
      if (q_write) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (q_read || (q_write && drop_old)) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (q_write && !drop_old && !q_read) begin
        level <= level + 9'd1;
      end else if (q_read && !(q_write && !drop_old)) begin
        level <= level - 9'd1;
      end
    end
  end

  wire [17:0] ram_q;
  sample_ram u_ram (
    .core_clk(core_clk),
    .rstn(rstn),
    .wr_en(q_write),
    .wr_addr(wr_ptr),
    .wr_data(head_word),
    .rd_en(q_read),
    .rd_addr(rd_ptr),
    .rd_data(ram_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read state machine: two data reads return one word, high byte then low
  reg [7:0] low_byte;

  always @* begin
    case (rd_state)
      RS_IDLE: begin
        next_rd_state = q_read ? RS_FETCH : RS_IDLE;
      end
      RS_FETCH: begin
        next_rd_state = RS_HOLD;
      end
      RS_HOLD: begin
        next_rd_state = rd_data ? RS_IDLE : RS_HOLD;
      end
      default: begin
        next_rd_state = RS_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rstn || ptr_clear) begin
      rd_state <= RS_IDLE;
      low_byte <= 8'h00;
    end else begin
      rd_state <= next_rd_state;
      if (rd_state == RS_FETCH) begin
        low_byte <= ram_q[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watermark flag and read data
  wire wm_hit;
  assign wm_hit = (level >= wmark);

  always @(posedge core_clk) begin
    if (!rstn) begin
      watermark_flag <= 1'b0;
      watermark_pin <= 1'b0;
    end else begin
      // set wins over the clearing read
      if (wm_hit) begin
        watermark_flag <= 1'b1;
      end else if (rd_stat) begin
        watermark_flag <= 1'b0;
      end
      watermark_pin <= watermark_flag;
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      // a data read that starts a fetch answers from the fetch, not from the strobe
      reg_rvalid <= (reg_rd && !q_read) || (rd_state == RS_FETCH);
      if (rd_state == RS_FETCH) begin
        // tag rides in bits 7:6 of the first byte; sample bits 9:8 are lost then
        if (queue_tag_enable) begin
          reg_rdata <= {ram_q[17:16], ram_q[15:10]};
        end else begin
          reg_rdata <= ram_q[15:8];
        end
      end else if (rd_state == RS_HOLD && rd_data) begin
        reg_rdata <= low_byte;
      end else if (reg_rd) begin
        case (reg_addr)
          `ROUTE_B_ADDR: reg_rdata <= route_b;
          `QCTRL_ADDR: reg_rdata <= qctrl;
          `WMARK_LO_ADDR: reg_rdata <= wmark_lo;
          `QSTAT_ADDR: reg_rdata <= {watermark_flag, q_full, q_empty, queue_triggered,
                                     3'b000, level[8]};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // fifo_cfg_and_irq_line1_map

//--- fifo_cfg_defs.vh
// Purpose: register offsets, field positions, reset values and queue sizes for the
//          second-pin routing map and the sample queue configuration
// Assumes: byte-wide register port, one access per cycle
// Notes:   queue depth of 320 words, 9-bit fill level
//
// How it works
// - bit 7 of route register sends nvm completion to pin b; resets to 1
// - bit 6 sends nvm request status to pin b; resets to 0
// - bit 5 sends latched undervoltage to pin b; resets to 0
// - bit 4 sends latched overrange to pin b; resets to 0
// - bit 3 sends parity fault to pin b; resets to 0
// - bit 2 sends triple tap to pin b; resets to 0
// - bit 1 sends double tap to pin b; resets to 0
// - bit 0 sends single tap to pin b; resets to 0
// - queue control bit 7 holds read, write pointers and read state at zero
// - tag enable puts the 2-bit channel id in high byte bits 7:6; sample bits 9:8 are dropped
// - tag enable off returns only the 16-bit signed sample
// - mode field bits 5:4: disabled, normal, stream, trigger; ignored in pdm
// - external trigger bit in trigger mode takes trigger from frame sync pin
// - external trigger bit low uses internal activity; only matters in mode 3
// - control bit 0 is watermark count bit 8; flag sets when fill >= count
// - watermark low byte register at 0x31, read-write, resets to zero
// - watermark flag sticks until the host reads it; the read clears it only while fill < count
`ifndef FIFO_CFG_DEFS_VH
`define FIFO_CFG_DEFS_VH

`define ROUTE_B_ADDR 8'h2e
`define QCTRL_ADDR 8'h30
`define WMARK_LO_ADDR 8'h31
`define QSTAT_ADDR 8'h3a
`define QDATA_ADDR 8'h3b

`define ROUTE_B_RESET 8'h80
`define QCTRL_RESET 8'h00
`define WMARK_LO_RESET 8'h00

`define QCTRL_PTR_CLR 7
`define QCTRL_TAG_EN 6
`define QCTRL_MODE_HI 5
`define QCTRL_MODE_LO 4
`define QCTRL_EXT_TRIG 3
`define QCTRL_WM_MSB 0
`define QCTRL_WR_MASK 8'hf9

`define MODE_OFF 2'h0
`define MODE_NORMAL 2'h1
`define MODE_STREAM 2'h2
`define MODE_TRIGGER 2'h3

`define QDEPTH 320
`define QAW 9
`define QDW 18

`endif

//--- sample_ram.v
// Purpose: sample queue storage, registered read data
// Assumes: single clock, one write and one read port
// Notes:   no reset on the array, only on the read register
`timescale 1ns/100ps
module sample_ram (
  input wire core_clk,
  input wire rstn,
  input wire wr_en,
  input wire [8:0] wr_addr,
  input wire [17:0] wr_data,
  input wire rd_en,
  input wire [8:0] rd_addr,
  output reg [17:0] rd_data
);
  reg [17:0] mem [0:319];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      rd_data <= 18'h00000;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // sample_ram

//--- fifo_cfg_monitor.sv
// Purpose: port checks for the routing map and queue config registers
// Assumes: one strobe per cycle, status inputs are core_clk levels
// Notes: pin b taken as one registered stage behind route and status
`timescale 1ns/100ps
`include "fifo_cfg_defs.vh"
module fifo_cfg_monitor (
  input wire core_clk,
  input wire rstn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire nvm_complete,
  input wire nvm_request,
  input wire undervolt_latched,
  input wire overrange_latched,
  input wire parity_fault,
  input wire tap3_event,
  input wire tap2_event,
  input wire tap1_event,
  input wire irq_pin_b
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire [7:0] st = {nvm_complete, nvm_request, undervolt_latched, overrange_latched,
    parity_fault, tap3_event, tap2_event, tap1_event};
  ////////////////////////////////////////////////////////////////////////////////
  AST_REG_RVALID: assert property (reg_rd && reg_addr != `QDATA_ADDR |=> reg_rvalid)
    else $error("register read gave no valid");
  AST_ROUTE_RW: assert property ((reg_wr && reg_addr == 8'h2e) ##1 (reg_rd && reg_addr == 8'h2e)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("route register readback wrong");
  AST_WM_LO_RW: assert property ((reg_wr && reg_addr == 8'h31) ##1 (reg_rd && reg_addr == 8'h31)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("watermark low byte readback wrong");
  AST_QCTRL_RW: assert property ((reg_wr && reg_addr == 8'h30) ##1 (reg_rd && reg_addr == 8'h30)
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'hf9)) else $error("queue control readback wrong");
  AST_IRQ_IDLE: assert property (st == 8'h00 |=> !irq_pin_b)
    else $error("pin b high with no status");
  AST_IRQ_MASKED: assert property ((reg_wr && reg_addr == 8'h2e && reg_wdata == 8'h00)
    ##1 (!reg_wr)[*2] |=> !irq_pin_b) else $error("pin b high with all routes off");
  AST_TAP1_ON: assert property ((reg_wr && reg_addr == 8'h2e && reg_wdata[0])
    ##1 (!reg_wr && tap1_event)[*2] |=> irq_pin_b) else $error("single tap not routed");
  AST_NVM_ON: assert property ((reg_wr && reg_addr == 8'h2e && reg_wdata[7])
    ##1 (!reg_wr && nvm_complete)[*2] |=> irq_pin_b) else $error("nvm completion not routed");
endmodule // fifo_cfg_monitor
bind fifo_cfg_and_irq_line1_map fifo_cfg_monitor u_mon (.core_clk, .rstn, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .nvm_complete, .nvm_request,
  .undervolt_latched, .overrange_latched, .parity_fault, .tap3_event, .tap2_event,
  .tap1_event, .irq_pin_b);

//--- sample_src.sv
// Purpose: sample producer facing the queue's write side
// Assumes: an offer is held until taken
// Notes: payload shows its inverse while nothing is offered
`timescale 1ns/100ps
module sample_src (
  input wire core_clk,
  input wire rstn,
  input wire en,
  input wire smp_ready,
  output reg smp_valid,
  output reg [1:0] smp_chan,
  output wire [15:0] smp_data
);
  reg [15:0] d;
  assign smp_data = smp_valid ? d : ~d;
  always @(posedge core_clk) begin
    if (!rstn) begin
      smp_valid <= 1'b0;
      smp_chan <= 2'h0;
      d <= 16'ha5c3;
    end else begin
      if (smp_valid && smp_ready) begin
        d <= d + 16'h0111;
        smp_chan <= smp_chan + 2'h1;
      end
      // never withdraw an offer that was not taken
      if (!smp_valid || smp_ready)
        smp_valid <= en;
    end
  end
endmodule // sample_src

//--- fifo_cfg_and_irq_line1_map_bench.sv
// Purpose: bench for routing map and queue config
// Assumes: one strobe per cycle, driven at the rising edge
// Notes: pdm mode held low, audio path out of scope
`timescale 1ns/100ps
`include "fifo_cfg_defs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module fifo_cfg_and_irq_line1_map_bench;
  reg core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, en = 0, fs = 0, act = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0, st = 0, d;
  wire [7:0] reg_rdata;
  wire reg_rvalid, smp_valid, smp_ready, irq_pin_b, trig, wm;
  wire [1:0] smp_chan;
  wire [15:0] smp_data;
  int n_errors = 0, checks = 0, i, n;
  // addr, write data, readback
  reg [23:0] rows [0:6] = '{24'h2effff, 24'h2e0000, 24'h30fff9, 24'h300000, 24'h31a5a5,
    24'h310000, 24'h405a00};
  fifo_cfg_and_irq_line1_map u_dut (.core_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .nvm_complete(st[7]), .nvm_request(st[6]), .undervolt_latched(st[5]),
    .overrange_latched(st[4]), .parity_fault(st[3]), .tap3_event(st[2]), .tap2_event(st[1]),
    .tap1_event(st[0]), .activity_event(act), .frame_sync_pin(fs), .pdm_mode(1'b0), .smp_valid,
    .smp_chan, .smp_data, .smp_ready, .irq_pin_b, .queue_triggered(trig), .watermark_pin(wm));
  sample_src u_src (.core_clk, .rstn, .en, .smp_ready, .smp_valid, .smp_chan, .smp_data);
  initial forever #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task wr(input [7:0] a, input [7:0] v);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task rd(input [7:0] a);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!reg_rvalid && n < 4);
    d = reg_rdata;
    `CHK("rvalid", 1'b1, reg_rvalid)
    // data port needs spacing between byte reads
    if (a == `QDATA_ADDR) repeat (2) @(posedge core_clk);
  endtask
  task end_sim;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1;
    @(posedge core_clk);
    rd(`ROUTE_B_ADDR);
    `CHK("route_rst", 8'h80, d)
    rd(`QCTRL_ADDR);
    `CHK("qctrl_rst", 8'h00, d)
    rd(`WMARK_LO_ADDR);
    `CHK("wm_lo_rst", 8'h00, d)
    for (i = 0; i < 7; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      `CHK("reg_rw", rows[i][7:0], d)
    end
    $display("done registers");
    for (i = 0; i < 8; i++) begin
      st <= 8'h01 << i;
      wr(`ROUTE_B_ADDR, 8'h01 << i);
      repeat (3) @(posedge core_clk);
      `CHK("irq_on", 1'b1, irq_pin_b)
      st <= ~(8'h01 << i);
      repeat (3) @(posedge core_clk);
      `CHK("irq_off", 1'b0, irq_pin_b)
    end
    st <= 8'hff;
    wr(`ROUTE_B_ADDR, 8'h00);
    repeat (3) @(posedge core_clk);
    `CHK("irq_masked", 1'b0, irq_pin_b)
    st <= 8'h00;
    $display("done routing");
    wr(`WMARK_LO_ADDR, 8'h03);
    @(posedge core_clk);
    wr(`QCTRL_ADDR, 8'h10);
    en <= 1;
    repeat (12) @(posedge core_clk);
    en <= 0;
    repeat (6) @(posedge core_clk);
    `CHK("wm_pin", 1'b1, wm)
    rd(`QSTAT_ADDR);
    `CHK("wm_flag", 1'b1, d[7])
    rd(`QDATA_ADDR);
    `CHK("hi_plain", 8'ha5, d)
    rd(`QDATA_ADDR);
    `CHK("lo_plain", 8'hc3, d)
    wr(`QCTRL_ADDR, 8'h50);
    rd(`QDATA_ADDR);
    `CHK("hi_tag", 8'h69, d)
    rd(`QDATA_ADDR);
    `CHK("lo_tag", 8'hd4, d)
    // stale pointers would leave words behind the clear
    wr(`QCTRL_ADDR, 8'h90);
    repeat (2) @(posedge core_clk);
    rd(`QSTAT_ADDR);
    `CHK("empty", 1'b1, d[5])
    `CHK("wm_stick", 1'b1, d[7])
    wr(`QCTRL_ADDR, 8'h00);
    rd(`QSTAT_ADDR);
    rd(`QSTAT_ADDR);
    `CHK("wm_clr", 1'b0, d[7])
    $display("done queue");
    wr(`QCTRL_ADDR, 8'h38);
    act <= 1;
    repeat (4) @(posedge core_clk);
    act <= 0;
    `CHK("trig_act_ignored", 1'b0, trig)
    fs <= 1;
    repeat (6) @(posedge core_clk);
    fs <= 0;
    `CHK("trig_ext", 1'b1, trig)
    wr(`QCTRL_ADDR, 8'hb0);
    @(posedge core_clk);
    wr(`QCTRL_ADDR, 8'h30);
    act <= 1;
    repeat (4) @(posedge core_clk);
    act <= 0;
    `CHK("trig_int", 1'b1, trig)
    $display("done trigger");
    // reset in mid-run must drop the trigger and restore the route default
    rstn <= 0;
    repeat (2) @(posedge core_clk);
    rstn <= 1;
    @(posedge core_clk);
    `CHK("trig_rst", 1'b0, trig)
    rd(`ROUTE_B_ADDR);
    `CHK("route_rst2", 8'h80, d)
    $display("done reset");
    end_sim;
  end
endmodule // fifo_cfg_and_irq_line1_map_bench
